// ---- scsr_pkg.sv ----
package scsr_pkg;

   // ---------------------------------------------------------------
   // widths and timing
   // ---------------------------------------------------------------
   localparam int          RESULT_BITS     = 16;
   localparam int          HEADER_BITS     = 2;
   localparam int          CLK_PERIOD_NS   = 50;
   localparam int          FIRST_BIT_NS    = 200;    // delay to first readable bit
   localparam int          DEADLINE_NS     = 150;    // readout deadline into next conv
   localparam int          MAX_PERIOD_NS   = 10000;  // longest time between conversions
   localparam int          FIRST_BIT_CYC   = (FIRST_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          DEADLINE_CYC    = (DEADLINE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                             (DEADLINE_NS / CLK_PERIOD_NS);
   localparam int          MAX_PERIOD_CYC  = MAX_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [1:0]  HEADER_CODE     = 2'h1;   // header sent 0 then 1
   localparam logic [1:0]  REF_ILLEGAL     = 2'h0;

   typedef enum logic {SCSR_ECHO, SCSR_SELF} scsr_mode_e;

   typedef struct packed {
      logic [RESULT_BITS-1:0] code;
      logic                   valid;
   } scsr_result_s;

endpackage : scsr_pkg

// ---- scsr_core.sv ----
// Behaviour
// - start high ends acquisition, conversion begins
// - sixteen binary trial steps, MSB first
// - latch decisions after last step
// - result readable after first-bit delay
// - 16-bit two's complement, MSB first
// - reference from select pins, both low illegal
// - starts ignored while converting
// - echo mode: copy clock, data on fall
// - self mode: 2-bit header, 18 pulses
// - first result invalid, and after long idle
`timescale 1ns/1ps
module scsr_core
   import scsr_pkg::*;
#(
   parameter int STEP_CYC = 1
) (
   // clock and reset
   input  wire logic        CLOCK,
   input  wire logic        RST,
   // conversion start
   input  wire logic        CNV_P,
   input  wire logic        CNV_N,
   input  wire logic        CNV_DIFF,
   // sampled comparator from analog array
   input  wire logic        COMP_IN,
   // readout
   input  wire logic        READ_CLK,
   input  wire logic        SELF_MODE,
   output logic             SDATA,
   output logic             ECHO_CLK,
   // reference selection
   input  wire logic        REF_SELECT_LOW,
   input  wire logic        REF_SELECT_HIGH,
   output logic [1:0]       REF_SOURCE,
   output logic             REF_FAULT,
   // status
   output logic             CONVERTING,
   output logic             SAMPLE_HOLD,
   output logic             RESULT_READY,
   output logic             RESULT_VALID
);
   initial begin
      if (STEP_CYC < 1) $error("STEP_CYC must be at least 1");
      // step counter is eight bits wide
      if (STEP_CYC > 256) $error("STEP_CYC must be at most 256");
   end

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [4:0] s1_ff, s2_ff;
   always_ff @(posedge CLOCK) begin
      s1_ff <= {CNV_P, CNV_N, READ_CLK, REF_SELECT_LOW, REF_SELECT_HIGH};
      s2_ff <= s1_ff;
   end
   logic cnv_s, rclk_s;
   // single-ended drive leaves the negative leg unused
   assign cnv_s  = CNV_DIFF ? (s2_ff[4] & ~s2_ff[3]) : s2_ff[4];
   assign rclk_s = s2_ff[2];

   logic cnv_d_ff, rclk_d_ff;
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         cnv_d_ff  <= 1'b0;
         rclk_d_ff <= 1'b0;
      end else begin
         cnv_d_ff  <= cnv_s;
         rclk_d_ff <= rclk_s;
      end
   end
   logic cnv_rise, rclk_rise, rclk_fall;
   assign cnv_rise  = cnv_s & ~cnv_d_ff;
   assign rclk_rise = rclk_s & ~rclk_d_ff;
   assign rclk_fall = ~rclk_s & rclk_d_ff;

   // ---------------------------------------------------------------
   // reference select
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         REF_SOURCE <= 2'h3;
         REF_FAULT  <= 1'b0;
      end else begin
         REF_SOURCE <= {s2_ff[0], s2_ff[1]};
         REF_FAULT  <= ({s2_ff[0], s2_ff[1]} == REF_ILLEGAL);
      end
   end

   // ---------------------------------------------------------------
   // successive approximation
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {ST_ACQ, ST_CONV, ST_DONE} scsr_state_e;
   scsr_state_e             state_ff;
   logic [RESULT_BITS-1:0]  trial_ff, weight_ff;
   logic [7:0]              step_cnt_ff;
   logic [15:0]             since_ff;      // cycles since conversion start
   logic                    first_ff, stale_ff;
   scsr_result_s            result_ff;
   logic                    step_tick;
   assign step_tick = (step_cnt_ff == 8'(STEP_CYC - 1));

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state_ff    <= ST_ACQ;
         trial_ff    <= 16'h0000;
         weight_ff   <= 16'h0000;
         step_cnt_ff <= 8'h00;
      end else begin
         case (state_ff)
            ST_ACQ: begin
               if (cnv_rise) begin
                  state_ff    <= ST_CONV;
                  weight_ff   <= 16'h8000;
                  trial_ff    <= 16'h8000;
                  step_cnt_ff <= 8'h00;
               end
            end
            ST_CONV: begin
               step_cnt_ff <= step_tick ? 8'h00 : step_cnt_ff + 8'h01;
               if (step_tick) begin
                  // comparator low keeps the trial bit, high drops it
                  if (COMP_IN) trial_ff <= (trial_ff & ~weight_ff) | (weight_ff >> 1);
                  else         trial_ff <= trial_ff | (weight_ff >> 1);
                  weight_ff <= weight_ff >> 1;
                  if (weight_ff == 16'h0001) state_ff <= ST_DONE;
               end
            end
            ST_DONE:  state_ff <= ST_ACQ;
            default:  state_ff <= ST_ACQ;
         endcase
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         CONVERTING  <= 1'b0;
         SAMPLE_HOLD <= 1'b0;
      end else begin
         CONVERTING  <= (state_ff == ST_CONV);
         SAMPLE_HOLD <= (state_ff == ST_CONV) || (state_ff == ST_ACQ && cnv_rise);
      end
   end

   // ---------------------------------------------------------------
   // result latch and validity
   // ---------------------------------------------------------------
   logic [RESULT_BITS-1:0] final_code;
   // bias flip turns the offset search into two's complement
   assign final_code = {~trial_ff[15], trial_ff[14:0]};
   logic pending_ff;   // conversion done, not yet published
   logic [RESULT_BITS-1:0] pend_code_ff;
   logic pend_valid_ff;
   logic shifting;

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         since_ff <= 16'h0000;
         first_ff <= 1'b1;
         stale_ff <= 1'b0;
      end else begin
         if (state_ff == ST_ACQ && cnv_rise) begin
            since_ff <= 16'h0000;
            stale_ff <= (since_ff >= 16'(MAX_PERIOD_CYC)) && !first_ff;
         end else if (since_ff != 16'hffff) begin
            since_ff <= since_ff + 16'h0001;
         end
         if (state_ff == ST_DONE) first_ff <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pending_ff    <= 1'b0;
         pend_code_ff  <= 16'h0000;
         pend_valid_ff <= 1'b0;
         result_ff     <= '0;
         RESULT_READY  <= 1'b0;
         RESULT_VALID  <= 1'b0;
      end else begin
         if (state_ff == ST_CONV && step_tick && weight_ff == 16'h0001) begin
            pending_ff    <= 1'b1;
            pend_code_ff  <= {final_code[15:1], ~COMP_IN ^ 1'b1 ? 1'b0 : 1'b1};
            pend_valid_ff <= !first_ff && !stale_ff;
         end
         if (state_ff == ST_ACQ && cnv_rise) RESULT_READY <= 1'b0;
         // publish only past the first-bit delay and outside a burst
         if (pending_ff && since_ff >= 16'(FIRST_BIT_CYC) && !shifting) begin
            pending_ff   <= 1'b0;
            result_ff    <= '{code: pend_code_ff, valid: pend_valid_ff};
            RESULT_READY <= 1'b1;
            RESULT_VALID <= pend_valid_ff;
         end
      end
   end

   // ---------------------------------------------------------------
   // serial readout
   // ---------------------------------------------------------------
   scsr_mode_e mode;
   assign mode = SELF_MODE ? SCSR_SELF : SCSR_ECHO;
   logic [RESULT_BITS+HEADER_BITS-1:0] shreg_ff;
   logic [4:0]                         bit_cnt_ff;
   logic [4:0]                         nbits;
   assign nbits    = (mode == SCSR_SELF) ? 5'(RESULT_BITS + HEADER_BITS) : 5'(RESULT_BITS);
   assign shifting = (bit_cnt_ff != 5'h00) && (bit_cnt_ff < nbits);

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         shreg_ff   <= '0;
         bit_cnt_ff <= 5'h00;
         SDATA      <= 1'b0;
      end else if (RESULT_READY && !shifting && bit_cnt_ff == 5'h00
                   && !(rclk_fall || rclk_rise)) begin
         shreg_ff <= (mode == SCSR_SELF) ? {HEADER_CODE, result_ff.code}
                                         : {result_ff.code, 2'h0};
         SDATA    <= (mode == SCSR_SELF) ? HEADER_CODE[1] : result_ff.code[15];
      end else if (rclk_fall && bit_cnt_ff < nbits) begin
         bit_cnt_ff <= bit_cnt_ff + 5'h01;
         shreg_ff   <= shreg_ff << 1;
         SDATA      <= (bit_cnt_ff + 5'h01 < nbits) ? shreg_ff[16] : 1'b0;
      end else if (!RESULT_READY) begin
         // no result ready (cleared at a new start): data held low, counter rearmed
         bit_cnt_ff <= 5'h00;
         SDATA      <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) ECHO_CLK <= 1'b0;
      else     ECHO_CLK <= (mode == SCSR_ECHO) ? rclk_s : 1'b0;
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence conv_start;
      state_ff == ST_ACQ && cnv_rise;
   endsequence
   a_start_enters_conv: assert property (@(posedge CLOCK) disable iff (RST)
      conv_start |=> state_ff == ST_CONV) else $error("start not taken");
   a_conv_length: assert property (@(posedge CLOCK) disable iff (RST)
      conv_start |=> (state_ff == ST_CONV)[*8]) else $error("conversion too short");
   a_ignore_restart: assert property (@(posedge CLOCK) disable iff (RST)
      state_ff == ST_CONV && !(step_tick && weight_ff == 16'h0001) |=> state_ff == ST_CONV)
      else $error("conversion aborted");
   a_ready_delay: assert property (@(posedge CLOCK) disable iff (RST)
      $rose(RESULT_READY) |-> since_ff > 16'(FIRST_BIT_CYC)) else $error("early result");
   a_hold_word: assert property (@(posedge CLOCK) disable iff (RST)
      shifting |=> $stable(result_ff)) else $error("word changed in burst");
   a_low_after_word: assert property (@(posedge CLOCK) disable iff (RST)
      bit_cnt_ff == nbits |-> !SDATA) else $error("data not low after word");
   a_echo_follows: assert property (@(posedge CLOCK) disable iff (RST)
      !SELF_MODE && $stable(SELF_MODE) |=> ECHO_CLK == $past(rclk_s)) else $error("echo");
   a_ref_fault: assert property (@(posedge CLOCK) disable iff (RST)
      REF_FAULT |-> REF_SOURCE == REF_ILLEGAL) else $error("ref fault mismatch");
   a_first_invalid: assert property (@(posedge CLOCK) disable iff (RST)
      first_ff && state_ff == ST_CONV && step_tick && weight_ff == 16'h0001
      |=> !pend_valid_ff) else $error("first result valid");
   a_self_count: assert property (@(posedge CLOCK) disable iff (RST)
      SELF_MODE |-> bit_cnt_ff <= 5'd18) else $error("self burst overrun");

endmodule : scsr_core

// ---- scsr_host.sv ----
`timescale 1ns/1ps
module scsr_host (
   // readout link
   output logic        READ_CLK,
   input  wire logic   SDATA,
   input  wire logic   ECHO_CLK
);
   initial READ_CLK = 1'b0;

   // clock stands still at the mode's idle level between bursts
   task automatic idle(input logic self);
      READ_CLK = self;
   endtask : idle

   // sample just before each fall: data only moves after a fall
   task automatic burst(input logic self, input int n, output logic [17:0] bits,
                        output logic [17:0] echoes);
      bits   = '0;
      echoes = '0;
      for (int i = 0; i < n; i++) begin
         if (!self) begin
            READ_CLK = 1'b1;
            #200;
         end
         bits     = {bits[16:0], SDATA};
         echoes   = {echoes[16:0], ECHO_CLK};
         READ_CLK = 1'b0;
         #200;
         if (self) begin
            READ_CLK = 1'b1;
            #200;
         end
      end
   endtask : burst
endmodule : scsr_host

// ---- test_sar_conversion_serial_readout.sv ----
`timescale 1ns/1ps
module test_sar_conversion_serial_readout;
   import scsr_pkg::*;
   localparam int STEP = 1;
   logic        clock, rst, cnv_p, cnv_n, cnv_diff, comp_in, read_clk, self_mode;
   logic        sdata, echo_clk, ref_low, ref_high, ref_fault;
   logic        converting, sample_hold, result_ready, result_valid;
   logic [1:0]  ref_source;
   int          miscompares = 0;
   int          comparisons = 0;
   int          run_len = 0;

   scsr_core #(.STEP_CYC(STEP)) u_dut (.CLOCK(clock), .RST(rst), .CNV_P(cnv_p),
      .CNV_N(cnv_n), .CNV_DIFF(cnv_diff), .COMP_IN(comp_in), .READ_CLK(read_clk),
      .SELF_MODE(self_mode), .SDATA(sdata), .ECHO_CLK(echo_clk),
      .REF_SELECT_LOW(ref_low), .REF_SELECT_HIGH(ref_high), .REF_SOURCE(ref_source),
      .REF_FAULT(ref_fault), .CONVERTING(converting), .SAMPLE_HOLD(sample_hold),
      .RESULT_READY(result_ready), .RESULT_VALID(result_valid));
   scsr_host u_host (.READ_CLK(read_clk), .SDATA(sdata), .ECHO_CLK(echo_clk));

   // ------------------------------------------------------------
   // clock, monitor, watchdog
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // restart count on a start pulse outside conversion only
   always @(posedge clock) begin
      if (converting === 1'b1) run_len <= run_len + 1;
      else if (cnv_p) run_len <= 0;
   end
   initial begin
      #300_000;
      miscompares++;
      $display("watchdog expired");
      conclude();
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic tick();
      @(posedge clock);
      #1;
   endtask : tick

   task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic pulse();
      cnv_p = 1'b1;
      cnv_n = 1'b0;
      repeat (2) tick();
      cnv_p = 1'b0;
      cnv_n = 1'b1;
      repeat (2) tick();
   endtask : pulse

   task automatic convert(input logic comp, input logic twice);
      int n;
      n       = 0;
      comp_in = comp;
      pulse();
      check("hold", 1'b1, sample_hold);
      check("busy", 1'b1, converting);
      if (twice) pulse();
      while (result_ready !== 1'b1 && n < 100) begin
         tick();
         n++;
      end
      repeat (2) tick();
      check("ready", 1'b1, result_ready);
      check("released", 1'b0, sample_hold);
      check("length", 16 * STEP, run_len[17:0]);
   endtask : convert

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic readout(input logic self, input logic comp, input logic twice,
                          input logic valid);
      logic [17:0] bits, echoes, code;
      int          n;
      self_mode = self;
      u_host.idle(self);
      tick();
      convert(comp, twice);
      code = comp ? 18'h0_8000 : 18'h0_7fff;
      if (self) code = {HEADER_CODE, code[15:0]};
      n = self ? 18 : 16;
      u_host.burst(self, n, bits, echoes);
      check("word", code, bits);
      check("echo", self ? 18'h0_0000 : 18'h0_ffff, echoes);
      check("valid", valid, result_valid);
      repeat (6) tick();
      check("tail", 1'b0, sdata);
      $display("readout self=%0d comp=%0d finished", self, comp);
   endtask : readout

   task automatic straps();
      for (int i = 0; i < 4; i++) begin
         {ref_high, ref_low} = i[1:0];
         repeat (4) tick();
         check("fault", i == 0, ref_fault);
         if (i != 0) check("source", i[1:0], ref_source);
      end
      {ref_high, ref_low} = 2'h3;
      $display("straps finished");
   endtask : straps

   task automatic conclude();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude

   initial begin
      {rst, cnv_p, cnv_n, cnv_diff, comp_in, self_mode} = 6'b101000;
      {ref_high, ref_low} = 2'h3;
      repeat (8) tick();
      rst = 1'b0;
      repeat (3) tick();
      readout(1'b0, 1'b1, 1'b0, 1'b0);
      readout(1'b1, 1'b0, 1'b1, 1'b1);
      cnv_diff = 1'b1;
      readout(1'b0, 1'b0, 1'b0, 1'b1);
      straps();
      // idle past the longest allowed period spoils the next word
      repeat (250) tick();
      readout(1'b1, 1'b1, 1'b0, 1'b0);
      conclude();
   end
endmodule : test_sar_conversion_serial_readout
